//--- hw/drcap_capture.sv
// Triggered disturbance capture: circular pre-trigger store and record stream.
// Assumes trigger, channel and setting inputs come from logic on ref_clk.
//
// Behaviour
// - Record only with trigger and activation on.
// - Record holds enabled analog and binary samples.
// - At most 64 binary, 32 analog channels.
// - Stored record bytes bounded at twelve megabytes.
// - Base rate: twenty samples per network period.
// - Dual rate selects twenty or forty per period.
// - Trigger section capped at maximum recording time.
// - Record starts with the pre-trigger samples.
// - Trigger drop ends the trigger section early.
// - Trigger must release before a new record.
// - Timer settings clamped to ranges, defaults at reset.
// - Warn when pre plus post exceeds maximum.
// - Framed stream feeds the record file writer.
`include "drcap_consts.svh"
module drcap_capture #(
   parameter int DUAL_RATE = 1,
   parameter int ANA_W     = 16,
   parameter int ANA_CH    = `DRC_ANA_CH,
   parameter int BIN_CH    = `DRC_BIN_CH,
   parameter int PRE_DEPTH = `DRC_PRE_DEPTH,
   parameter int DIV_50_20 = `DRC_CLK_HZ / (`DRC_NET_50HZ * `DRC_SPP_BASE),
   parameter int DIV_60_20 = `DRC_CLK_HZ / (`DRC_NET_60HZ * `DRC_SPP_BASE),
   parameter int DIV_50_40 = `DRC_CLK_HZ / (`DRC_NET_50HZ * `DRC_SPP_DUAL),
   parameter int DIV_60_40 = `DRC_CLK_HZ / (`DRC_NET_60HZ * `DRC_SPP_DUAL),
   parameter logic [23:0] STORE_BYTES = `DRC_STORE_BYTES,
   localparam int DW = ANA_CH * ANA_W + BIN_CH,
   localparam int AW = $clog2(PRE_DEPTH)
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    recorder_activation,
   input  wire logic                    sample_rate_select,
   input  wire logic                    net_60hz,
   input  wire logic [13:0]             pre_trigger_time,
   input  wire logic [13:0]             post_window_setting,
   input  wire logic [13:0]             max_record_time,
   input  wire logic [ANA_CH-1:0]       ana_enable,
   input  wire logic [BIN_CH-1:0]       bin_enable,
   input  wire logic [ANA_CH*ANA_W-1:0] ana_in,
   input  wire logic [BIN_CH-1:0]       bin_in,
   input  wire logic                    trigger_in,
   input  wire logic                    storage_release,
   output logic                         rec_valid,
   input  wire logic                    rec_ready,
   output logic [DW-1:0]                rec_data,
   output logic                         rec_first,
   output logic                         rec_last,
   output logic                         recording,
   output logic                         settings_warning,
   output logic                         storage_full
);
   localparam logic [23:0] WORD_BYTES = 24'(DW / 8);
   // The flag lags the count by a cycle and the closing word must still fit.
   localparam logic [23:0] FULL_MARGIN = 24'(`DRC_FULL_WORDS * (DW / 8));

   // ********************************************************************
   // Helpers
   // ********************************************************************
   function automatic logic [13:0] clamp(input logic [13:0] v, input logic [13:0] lo,
                                         input logic [13:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [15:0] samples_of(input logic [13:0] ms, input logic [31:0] sps);
      logic [31:0] p;
      p = {18'h0_0000, ms} * sps / `DRC_MS_PER_S;
      samples_of = p[15:0];
   endfunction

   drcap_pkg::drcap_state_t state_q;
   logic [13:0] pre_q, post_q, max_q;
   logic [31:0] sps, div;
   logic [31:0] div_cnt_q;
   logic        tick_q;
   logic [DW-1:0] store [PRE_DEPTH];
   logic [DW-1:0] sample_d;
   logic [AW-1:0] wr_q, rd_q, end_q;
   logic [AW:0]   fill_q;
   logic [15:0]   sec_cnt_q;
   logic          released_q, first_pend_q;
   logic [23:0]   bytes_q;
   logic          in_ready, rd_avail, rd_last, rd_take, push;
   logic [15:0]   pre_n;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(PRE_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // The depth need not be a power of two, so stepping back wraps by hand.
   function automatic logic [AW-1:0] ptr_back(input logic [AW-1:0] p, input logic [15:0] n);
      ptr_back = (int'(p) >= int'(n)) ? p - AW'(n) : p + AW'(PRE_DEPTH) - AW'(n);
   endfunction

   // ********************************************************************
   // Settings and sample clock
   // ********************************************************************
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pre_q            <= `DRC_WIN_DEF;
         post_q           <= `DRC_WIN_DEF;
         max_q            <= `DRC_REC_DEF;
         settings_warning <= 1'b0;
      end
      else
      begin
         pre_q            <= clamp(pre_trigger_time, `DRC_WIN_MIN, `DRC_WIN_MAX);
         post_q           <= clamp(post_window_setting, `DRC_WIN_MIN, `DRC_WIN_MAX);
         max_q            <= clamp(max_record_time, `DRC_REC_MIN, `DRC_REC_MAX);
         settings_warning <= ({1'b0, pre_q} + {1'b0, post_q}) > {1'b0, max_q};
      end
   end

   // The optional doubled rate exists only in the dual-rate build.
   always_comb
   begin
      sps = (net_60hz ? `DRC_NET_60HZ : `DRC_NET_50HZ) *
            ((DUAL_RATE != 0 && sample_rate_select) ? `DRC_SPP_DUAL : `DRC_SPP_BASE);
      if (DUAL_RATE != 0 && sample_rate_select)
         div = net_60hz ? 32'(DIV_60_40) : 32'(DIV_50_40);
      else
         div = net_60hz ? 32'(DIV_60_20) : 32'(DIV_50_20);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         div_cnt_q <= '0;
         tick_q    <= 1'b0;
      end
      else
      begin
         tick_q    <= (div_cnt_q >= div - 1);
         div_cnt_q <= (div_cnt_q >= div - 1) ? '0 : div_cnt_q + 1;
      end
   end

   // ********************************************************************
   // Circular sample store
   // ********************************************************************
   // Disabled channels record as zero so the word layout never changes.
   always_comb
   begin
      sample_d = '0;
      for (int i = 0; i < ANA_CH; i++)
         if (ana_enable[i])
            sample_d[i*ANA_W +: ANA_W] = ana_in[i*ANA_W +: ANA_W];
      sample_d[DW-1 -: BIN_CH] = bin_in & bin_enable;
   end

   always_ff @(posedge ref_clk)
   begin
      if (tick_q && state_q != drcap_pkg::DRCAP_IDLE)
         store[wr_q] <= sample_d;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q   <= '0;
         fill_q <= '0;
      end
      else if (state_q == drcap_pkg::DRCAP_IDLE)
         fill_q <= '0;
      else if (tick_q)
      begin
         wr_q   <= inc(wr_q);
         // One slot stays free so a full window never reads as an empty one.
         if (fill_q != (AW+1)'(PRE_DEPTH - 1))
            fill_q <= fill_q + 1'b1;
      end
   end

   // ********************************************************************
   // Record sequence
   // ********************************************************************
   assign pre_n = (16'(fill_q) < samples_of(pre_q, sps)) ? 16'(fill_q) : samples_of(pre_q, sps);
   assign rd_avail = (state_q == drcap_pkg::DRCAP_DRAIN) ? (rd_q != end_q) :
                     (state_q == drcap_pkg::DRCAP_TRIG || state_q == drcap_pkg::DRCAP_POST) &&
                     (rd_q != wr_q);
   assign rd_last  = (state_q == drcap_pkg::DRCAP_DRAIN) && (inc(rd_q) == end_q);
   // Words past the storage budget are dropped; the closing word still goes out.
   assign push     = rd_avail && (!storage_full || rd_last);
   assign rd_take  = rd_avail && (in_ready || !push);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         released_q <= 1'b0;
      else if (!trigger_in)
         released_q <= 1'b1;
      else if (state_q == drcap_pkg::DRCAP_ARMED && recorder_activation)
         released_q <= 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q   <= drcap_pkg::DRCAP_IDLE;
         sec_cnt_q <= '0;
         rd_q      <= '0;
         end_q     <= '0;
         first_pend_q <= 1'b0;
      end
      else
      begin
         if (rd_take)
            rd_q <= inc(rd_q);
         if (push && in_ready)
            first_pend_q <= 1'b0;
         unique case (state_q)
            drcap_pkg::DRCAP_IDLE:
               if (recorder_activation)
                  state_q <= drcap_pkg::DRCAP_ARMED;
            drcap_pkg::DRCAP_ARMED:
               if (!recorder_activation)
                  state_q <= drcap_pkg::DRCAP_IDLE;
               else if (trigger_in && released_q && !storage_full)
               begin
                  state_q      <= drcap_pkg::DRCAP_TRIG;
                  rd_q         <= ptr_back(wr_q, pre_n);
                  sec_cnt_q    <= '0;
                  first_pend_q <= 1'b1;
               end
            drcap_pkg::DRCAP_TRIG:
               if (!trigger_in)
               begin
                  state_q   <= drcap_pkg::DRCAP_POST;
                  sec_cnt_q <= '0;
               end
               else if (tick_q)
               begin
                  if (sec_cnt_q + 1'b1 >= samples_of(max_q, sps))
                  begin
                     state_q   <= drcap_pkg::DRCAP_POST;
                     sec_cnt_q <= '0;
                  end
                  else
                     sec_cnt_q <= sec_cnt_q + 1'b1;
               end
            drcap_pkg::DRCAP_POST:
               if (tick_q)
               begin
                  sec_cnt_q <= sec_cnt_q + 1'b1;
                  if (sec_cnt_q + 1'b1 >= samples_of(post_q, sps))
                  begin
                     state_q <= drcap_pkg::DRCAP_DRAIN;
                     end_q   <= inc(wr_q);
                  end
               end
            drcap_pkg::DRCAP_DRAIN:
               if (rd_take && rd_last)
                  state_q <= drcap_pkg::DRCAP_ARMED;
            default:
               state_q <= drcap_pkg::DRCAP_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         bytes_q      <= '0;
         storage_full <= 1'b0;
         recording    <= 1'b0;
      end
      else
      begin
         recording <= (state_q != drcap_pkg::DRCAP_IDLE) && (state_q != drcap_pkg::DRCAP_ARMED);
         // A word taken in the release cycle still counts against the fresh budget.
         if (storage_release)
            bytes_q <= (push && in_ready) ? WORD_BYTES : '0;
         else if (push && in_ready)
            bytes_q <= bytes_q + WORD_BYTES;
         storage_full <= !storage_release && (bytes_q + FULL_MARGIN > STORE_BYTES);
      end
   end

   // The writer turns each first..last frame into the configuration, data and comment files.
   drcap_buf2 #(
      .W (DW + 2)
   ) u_buf (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (in_ready),
      .in_data   ({first_pend_q, rd_last, store[rd_q]}),
      .out_valid (rec_valid),
      .out_ready (rec_ready),
      .out_data  ({rec_first, rec_last, rec_data})
   );

   // ********************************************************************
   // Checks
   // ********************************************************************
   sequence s_armed_trig;
      state_q == drcap_pkg::DRCAP_ARMED && trigger_in && released_q && !storage_full;
   endsequence

   chk_start_needs_enable: assert property (@(posedge ref_clk) disable iff (rst)
      (state_q == drcap_pkg::DRCAP_ARMED && !recorder_activation) |=> state_q != drcap_pkg::DRCAP_TRIG)
      else $error("record started while activation off");
   chk_start_on_trigger: assert property (@(posedge ref_clk) disable iff (rst)
      (s_armed_trig and recorder_activation) |=> state_q == drcap_pkg::DRCAP_TRIG)
      else $error("trigger not taken");
   chk_rearm_release: assert property (@(posedge ref_clk) disable iff (rst)
      ($rose(state_q == drcap_pkg::DRCAP_TRIG)) |-> $past(released_q))
      else $error("record started without trigger release");
   chk_trig_cap: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == drcap_pkg::DRCAP_TRIG |-> sec_cnt_q < samples_of(max_q, sps))
      else $error("trigger section exceeds maximum");
   chk_trig_drop: assert property (@(posedge ref_clk) disable iff (rst)
      (state_q == drcap_pkg::DRCAP_TRIG && !trigger_in) |=> state_q == drcap_pkg::DRCAP_POST)
      else $error("trigger drop did not end section");
   chk_post_window: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(state_q == drcap_pkg::DRCAP_DRAIN) |-> $past(sec_cnt_q) + 1'b1 == samples_of(post_q, sps))
      else $error("post window length wrong");
   chk_warn_sum: assert property (@(posedge ref_clk) disable iff (rst)
      ##1 settings_warning == ($past(pre_q) + $past(post_q) > {1'b0, $past(max_q)}))
      else $error("settings warning mismatch");
   chk_settings_range: assert property (@(posedge ref_clk) disable iff (rst)
      pre_q >= `DRC_WIN_MIN && pre_q <= `DRC_WIN_MAX && max_q >= `DRC_REC_MIN && max_q <= `DRC_REC_MAX)
      else $error("timer setting out of range");
   chk_pre_offset: assert property (@(posedge ref_clk) disable iff (rst)
      s_armed_trig ##1 state_q == drcap_pkg::DRCAP_TRIG |-> rd_q == ptr_back($past(wr_q), $past(pre_n)))
      else $error("pre-trigger start point wrong");
   chk_tick_period: assert property (@(posedge ref_clk) disable iff (rst)
      (tick_q && $stable(div)) |=> !tick_q)
      else $error("sample tick too frequent");
   chk_budget: assert property (@(posedge ref_clk) disable iff (rst)
      bytes_q <= STORE_BYTES)
      else $error("storage budget exceeded");
endmodule

//--- common/drcap_consts.svh
// Timing, range and budget constants of the disturbance capture block.
// Assumes a 10 MHz reference clock and millisecond timer settings.
`ifndef DRCAP_CONSTS_SVH
`define DRCAP_CONSTS_SVH
`define DRC_CLK_HZ      32'h0098_9680
`define DRC_NET_50HZ    32'h0000_0032
`define DRC_NET_60HZ    32'h0000_003C
`define DRC_SPP_BASE    32'h0000_0014
`define DRC_SPP_DUAL    32'h0000_0028
`define DRC_MS_PER_S    32'h0000_03E8
`define DRC_WIN_MIN     14'h0064
`define DRC_WIN_MAX     14'h03E8
`define DRC_WIN_DEF     14'h00C8
`define DRC_REC_MIN     14'h01F4
`define DRC_REC_MAX     14'h2710
`define DRC_REC_DEF     14'h03E8
`define DRC_STORE_BYTES 24'hC0_0000
`define DRC_ANA_CH      32'h0000_0020
`define DRC_BIN_CH      32'h0000_0040
`define DRC_PRE_DEPTH   32'h0000_0960
`define DRC_FULL_WORDS  24'h00_0003
`endif

//--- common/drcap_pkg.sv
// Types shared by the disturbance capture block.
// Assumes the constants header is included by the design files.
package drcap_pkg;
   typedef enum logic [2:0] {
      DRCAP_IDLE  = 3'b000,
      DRCAP_ARMED = 3'b001,
      DRCAP_TRIG  = 3'b010,
      DRCAP_POST  = 3'b011,
      DRCAP_DRAIN = 3'b100
   } drcap_state_t;
endpackage

//--- hw/drcap_buf2.sv
// Two-entry valid/ready buffer on the record word path.
// Assumes source and sink run on ref_clk; the head entry drives the outputs.
module drcap_buf2 #(
   parameter int W = 8
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] spare_q;
   logic         spare_v_q;
   logic         push;
   logic         pop;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;

   // Ready is a flop, so the source never sees a combinational path from the sink.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         out_valid <= 1'b0;
         spare_v_q <= 1'b0;
         in_ready  <= 1'b1;
      end
      else
      begin
         if (pop)
         begin
            out_valid <= spare_v_q || push;
            spare_v_q <= spare_v_q && push;
            in_ready  <= 1'b1;
         end
         else if (push)
         begin
            out_valid <= 1'b1;
            spare_v_q <= out_valid;
            in_ready  <= !out_valid;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         out_data <= '0;
         spare_q  <= '0;
      end
      else
      begin
         if (pop)
            out_data <= spare_v_q ? spare_q : in_data;
         else if (push && !out_valid)
            out_data <= in_data;
         if (push && out_valid && !pop)
            spare_q <= in_data;
         else if (push && spare_v_q)
            spare_q <= in_data;
      end
   end

   chk_buf_no_loss: assert property (@(posedge ref_clk) disable iff (rst)
      (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
      else $error("buffer head changed while stalled");
endmodule

//--- bench/drcap_src_model.sv
// Channel source and record sink model standing beside the capture block.
// Assumes ref_clk from the bench; every output changes 2 ns after a rising edge.
module drcap_src_model (
   input  wire logic   ref_clk,
   input  wire logic   rst,
   input  wire logic   stall_en,
   output logic [511:0] ana_in,
   output logic [63:0]  bin_in,
   output logic         rec_ready,
   output logic [15:0]  cnt
);
   timeunit 1ns;
   timeprecision 1ps;

   // A running count makes every sample unique, so a lost or repeated word shows.
   initial
   begin
      cnt       = 16'h0000;
      rec_ready = 1'b1;
      forever
      begin
         @(posedge ref_clk);
         #2;
         cnt       = rst ? 16'h0000 : cnt + 16'h0001;
         rec_ready = !(stall_en && ($urandom_range(3) == 0));
      end
   end

   always_comb
   begin
      for (int i = 0; i < 32; i++)
         ana_in[i*16 +: 16] = cnt + 16'(i);
      bin_in = {4{cnt}};
   end
endmodule

//--- bench/disturbance_recorder_capture_tb.sv
// Self-checking bench for the disturbance capture block.
// Assumes short sample dividers, so one network period lasts only 160 to 200 cycles.
module disturbance_recorder_capture_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [15:0] trig_v;
      int          pre_n;
      int          div;
      int          lo;
      int          hi;
      bit          exact;
      logic [31:0] ae;
      logic [63:0] be;
   } drcap_note_t;

   logic          ref_clk;
   logic          rst;
   logic          recorder_activation;
   logic          sample_rate_select;
   logic          net_60hz;
   logic [13:0]   pre_trigger_time;
   logic [13:0]   post_window_setting;
   logic [13:0]   max_record_time;
   logic [31:0]   ana_enable;
   logic [63:0]   bin_enable;
   logic [511:0]  ana_in;
   logic [63:0]   bin_in;
   logic          trigger_in;
   logic          storage_release;
   logic          rec_valid;
   logic          rec_ready;
   logic [575:0]  rec_data;
   logic          rec_first;
   logic          rec_last;
   logic          recording;
   logic          settings_warning;
   logic          storage_full;
   logic          stall_en;
   logic [15:0]   cnt;
   int            err_total;
   int            comparisons;
   drcap_note_t   exp_q[$];
   int            dtab[4] = '{10, 8, 5, 4};
   logic [13:0]   wp[5] = '{14'h03E8, 14'h03E8, 14'h0000, 14'h3FFF, 14'h3FFF};
   logic [13:0]   wq[5] = '{14'h03E8, 14'h03E8, 14'h0000, 14'h3FFF, 14'h0000};
   logic [13:0]   wm[5] = '{14'h07CF, 14'h07D0, 14'h0000, 14'h0000, 14'h3FFF};
   logic          we[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

   // Full channel widths are kept so the largest configuration is exercised.
   drcap_capture #(
      .DIV_50_20   (10),
      .DIV_60_20   (8),
      .DIV_50_40   (5),
      .DIV_60_40   (4),
      .STORE_BYTES (24'h00_F000)
   ) i_drcap_capture (
      .ref_clk (ref_clk), .rst (rst), .recorder_activation (recorder_activation),
      .sample_rate_select (sample_rate_select), .net_60hz (net_60hz),
      .pre_trigger_time (pre_trigger_time), .post_window_setting (post_window_setting),
      .max_record_time (max_record_time), .ana_enable (ana_enable), .bin_enable (bin_enable),
      .ana_in (ana_in), .bin_in (bin_in), .trigger_in (trigger_in),
      .storage_release (storage_release), .rec_valid (rec_valid), .rec_ready (rec_ready),
      .rec_data (rec_data), .rec_first (rec_first), .rec_last (rec_last),
      .recording (recording), .settings_warning (settings_warning),
      .storage_full (storage_full)
   );

   drcap_src_model i_drcap_src_model (
      .ref_clk (ref_clk), .rst (rst), .stall_en (stall_en), .ana_in (ana_in),
      .bin_in (bin_in), .rec_ready (rec_ready), .cnt (cnt)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [575:0] seen, input logic [575:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask

   task automatic wait_rec(input logic lvl, input int lim);
      int n;
      n = 0;
      while (recording !== lvl && n < lim)
      begin
         tick(1);
         n++;
      end
      if (recording !== lvl)
      begin
         check(576'(recording), 576'(lvl));
         end_of_test();
      end
   endtask

   function automatic logic [575:0] exp_word(input logic [15:0] v, input logic [31:0] ae,
                                             input logic [63:0] be);
      logic [575:0] w;
      for (int i = 0; i < 32; i++)
         w[i*16 +: 16] = ae[i] ? v + 16'(i) : 16'h0000;
      w[575:512] = {4{v}} & be;
      return w;
   endfunction

   // One record: arm long enough to fill the pre-trigger window, trigger, then release.
   task automatic run_record(input int div, input int pre_n, input int hi_cyc, input int lo,
                             input int hi, input bit exact, input bit held);
      drcap_note_t n;
      tick(pre_n * div + 40);
      n.trig_v = cnt;
      n.pre_n  = pre_n;
      n.div    = div;
      n.lo     = lo;
      n.hi     = hi;
      n.exact  = exact;
      n.ae     = ana_enable;
      n.be     = bin_enable;
      exp_q.push_back(n);
      trigger_in = 1'b1;
      wait_rec(1'b1, 5);
      tick(hi_cyc);
      if (held)
         check(576'(recording), 576'(0));
      trigger_in = 1'b0;
      wait_rec(1'b0, (2 * pre_n + 10) * div + 600);
   endtask

   // ****************************************
   // Record stream monitor
   // ****************************************
   initial
   begin
      drcap_note_t  cur;
      int           words;
      logic [15:0]  pv;
      logic [15:0]  v;
      logic [15:0]  d;
      cur.div   = 1;
      cur.exact = 1'b0;
      words     = 0;
      pv        = 16'h0000;
      forever
      begin
         @(posedge ref_clk);
         if (rec_valid === 1'b1 && rec_ready === 1'b1)
         begin
            v = rec_data[15:0];
            if (rec_first === 1'b1)
            begin
               if (exp_q.size() == 0)
                  check(576'(1), 576'(0));
               else
                  cur = exp_q.pop_front();
               d = cur.trig_v - v;
               check(576'(d + cur.div + 2 >= cur.pre_n * cur.div &&
                          d <= cur.pre_n * cur.div + cur.div + 2), 576'(1));
               words = 0;
            end
            else
            begin
               d = v - pv;
               if (cur.exact)
                  check(576'(d), 576'(cur.div));
               else
                  check(576'(d % cur.div), 576'(0));
            end
            check(rec_data, exp_word(v, cur.ae, cur.be));
            words++;
            pv = v;
            if (rec_last === 1'b1 && cur.exact)
               check(576'(words >= cur.lo && words <= cur.hi), 576'(1));
         end
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      int pn;
      int dv;
      err_total           = 0;
      comparisons         = 0;
      rst                 = 1'b1;
      recorder_activation = 1'b0;
      sample_rate_select  = 1'b0;
      net_60hz            = 1'b0;
      pre_trigger_time    = 14'h0064;
      post_window_setting = 14'h0064;
      max_record_time     = 14'h01F4;
      ana_enable          = 32'hFFFF_FFFF;
      bin_enable          = 64'hFFFF_FFFF_FFFF_FFFF;
      trigger_in          = 1'b0;
      storage_release     = 1'b0;
      stall_en            = 1'b0;
      void'($urandom(32'h0ae7_2798));
      tick(5);
      rst = 1'b0;
      check(576'({recording, rec_valid, storage_full}), 576'(0));
      for (int k = 0; k < 5; k++)
      begin
         pre_trigger_time    = wp[k];
         post_window_setting = wq[k];
         max_record_time     = wm[k];
         tick(3);
         check(576'(settings_warning), 576'(we[k]));
      end
      pre_trigger_time    = 14'h0064;
      post_window_setting = 14'h0064;
      max_record_time     = 14'h01F4;
      trigger_in          = 1'b1;
      repeat (50)
      begin
         tick(1);
         check(576'(recording), 576'(0));
      end
      trigger_in          = 1'b0;
      recorder_activation = 1'b1;
      stall_en            = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         net_60hz           = m[0];
         sample_rate_select = m[1];
         ana_enable         = $urandom() | 32'h0000_0001;
         bin_enable         = {$urandom(), $urandom()};
         storage_release    = 1'b1;
         tick(1);
         storage_release    = 1'b0;
         pn = 100 * (m[0] ? 60 : 50) * (m[1] ? 40 : 20) / 1000;
         dv = dtab[m];
         run_record(dv, pn, 300, 2 * pn + 300 / dv - 2, 2 * pn + 300 / dv + 2, 1'b1, 1'b0);
      end
      net_60hz           = 1'b0;
      sample_rate_select = 1'b0;
      storage_release    = 1'b1;
      tick(1);
      storage_release    = 1'b0;
      run_record(10, 100, 7000, 698, 702, 1'b1, 1'b1);
      run_record(10, 100, 300, 0, 0, 1'b0, 1'b0);
      check(576'(storage_full), 576'(1));
      trigger_in = 1'b1;
      tick(100);
      check(576'(recording), 576'(0));
      trigger_in      = 1'b0;
      storage_release = 1'b1;
      tick(1);
      storage_release = 1'b0;
      tick(3);
      check(576'(storage_full), 576'(0));
      tick(20);
      check(576'(exp_q.size()), 576'(0));
      end_of_test();
   end
endmodule
